// ---- verilog/gige_cfg_pkg.sv ----
// Purpose: constants shared by the gigabit controller register bank
// Assumes: byte addresses on the register port, 32-bit data lanes
// Notes:   offsets are the byte addresses the host uses directly
package gige_cfg_pkg;
  // register byte addresses
  localparam logic [7:0] ADDR_LINK_STATUS  = 8'h6C;
  localparam logic [7:0] ADDR_RX_MAX_SIZE  = 8'hDA;
  localparam logic [7:0] ADDR_EXT_COMMAND  = 8'hE0;
  localparam logic [7:0] ADDR_RX_RING_LO   = 8'hE4;
  localparam logic [7:0] ADDR_RX_RING_HI   = 8'hE8;
  localparam logic [7:0] ADDR_TX_MAX_SIZE  = 8'hEC;

  // access width code carried beside each write
  localparam logic [1:0] SIZE_BYTE  = 2'h0;
  localparam logic [1:0] SIZE_WORD  = 2'h1;
  localparam logic [1:0] SIZE_DWORD = 2'h2;

  // link status bit positions
  localparam int LS_TX_PAUSE   = 6;
  localparam int LS_RX_PAUSE   = 5;
  localparam int LS_GIG_FULL   = 4;
  localparam int LS_SPEED_100  = 3;
  localparam int LS_SPEED_10   = 2;
  localparam int LS_LINK_UP    = 1;
  localparam int LS_DUPLEX     = 0;

  // extended command bit positions
  localparam int EC_ENDIAN     = 9;
  localparam int EC_TAG_STRIP  = 6;
  localparam int EC_CSUM       = 5;
  localparam int EC_DUAL_ADDR  = 4;
  localparam int EC_MULTI_XFER = 3;

  // media interface kinds
  localparam logic [1:0] MEDIA_GMII = 2'h0;
  localparam logic [1:0] MEDIA_MII  = 2'h1;
  localparam logic [1:0] MEDIA_TBI  = 2'h2;

  // values after reset
  localparam logic [13:0] RST_RX_MAX_SIZE = 14'h0000;
  localparam logic [5:0]  RST_TX_MAX_SIZE = 6'h00;
  localparam logic [7:0]  RST_LINK_STATUS = 8'h00;

  // size limits and thresholds
  localparam logic [13:0] RX_LONG_LIMIT   = 14'h1FFF;  // 8191 bytes
  localparam logic [5:0]  TX_JUMBO_THRESH = 6'h3B;
  localparam logic [19:0] TX_JUMBO_LIMIT  = 20'h01D10; // 7440 bytes
  localparam int          RING_ALIGN_BITS = 8;          // 256-byte grain
  localparam logic [2:0]  BURST_UNLIMITED = 3'h7;

  // timing: refresh strictly inside the 300 us window
  localparam int LINK_REFRESH_NS  = 300000;
  localparam int CLK_PERIOD_NS    = 4;
  localparam int LINK_REFRESH_CYC = LINK_REFRESH_NS / CLK_PERIOD_NS - 1;
endpackage : gige_cfg_pkg

// ---- verilog/gige_mac_config_status_regs.sv ----
// Purpose: configuration and status registers of a gigabit controller
// Assumes: one clock, inputs synchronous, host port never waits
// Notes:   read data appear exactly one cycle after the read strobe
`timescale 1ns/1ps

module gige_mac_config_status_regs #(
  parameter int REFRESH_CYCLES = gige_cfg_pkg::LINK_REFRESH_CYC,
  parameter int TX_UNIT_BYTES  = 128  // 32 on the smaller variant
) (
  input  wire logic        CLK,            // 250 MHz bus clock
  input  wire logic        SYS_RST,        // sync reset, active high
  // host register port
  input  wire logic [7:0]  ADDR,           // byte address
  input  wire logic [31:0] WDATA,          // write data, low lanes first
  input  wire logic [1:0]  WSIZE,          // width of this write
  input  wire logic        WR,             // write strobe
  input  wire logic        RD,             // read strobe
  output logic      [31:0] RDATA,          // read data, cycle after RD
  // live media state from the phy side
  input  wire logic [1:0]  MEDIA_MODE,     // gmii, mii or tbi
  input  wire logic        PHY_LINK,       // link established
  input  wire logic        PHY_FULL,       // full duplex
  input  wire logic        PHY_GIG,        // running at 1000
  input  wire logic        PHY_HUNDRED,    // running at 100
  input  wire logic        PHY_TEN,        // running at 10
  input  wire logic        PHY_TX_PAUSE,   // tx pause negotiated
  input  wire logic        PHY_RX_PAUSE,   // rx pause negotiated
  // dma burst settings held elsewhere
  input  wire logic [2:0]  TX_BURST_CFG,   // programmed tx burst
  input  wire logic [2:0]  RX_BURST_CFG,   // programmed rx burst
  // received packet report
  input  wire logic        RX_DONE,        // one-cycle end of packet
  input  wire logic [13:0] RX_LEN,         // packet length in bytes
  input  wire logic        RX_CRC_ERR,     // crc check failed
  // transmit length check
  input  wire logic        TX_REQ,         // one-cycle length query
  input  wire logic [13:0] TX_LEN,         // length incl. crc
  // control outputs
  output logic             RX_ENABLE,      // rx size nonzero
  output logic             TAG_STRIP_EN,   // strip vlan tags
  output logic             CSUM_EN,        // rx checksum offload
  output logic             DUAL_ADDR_RX,   // 64-bit cycles for ring
  output logic             BIG_ENDIAN,     // descriptor byte order
  output logic [2:0]       TX_BURST,       // effective tx burst
  output logic [2:0]       RX_BURST,       // effective rx burst
  output logic [63:0]      RING_BASE,      // aligned ring base
  output logic             RX_STAT_VALID,  // descriptor flags valid
  output logic             RX_WDOG_FLAG,   // watchdog-timeout flag
  output logic             RX_ERR_FLAG,    // error-summary flag
  output logic             RX_GOOD,        // packet judged good
  output logic             TX_ANS_VALID,   // length answer valid
  output logic             TX_ALLOW        // length within limit
);

  // the whole register state of the block
  typedef struct packed {
    logic [31:0] rdata;       // read answer
    logic [7:0]  link_status; // sampled media state
    logic [16:0] refresh_cnt; // cycles to next sample
    logic [13:0] rx_max;      // rx maximum size
    logic        endian;      // command bit 9
    logic        tag_strip;   // command bit 6
    logic        csum;        // command bit 5
    logic        dual_addr;   // command bit 4
    logic        multi_xfer;  // command bit 3
    logic [55:0] ring_base;   // base above the alignment bits
    logic [5:0]  tx_max;      // tx maximum size code
    logic        rx_enable;   // derived
    logic        dual_rx;     // derived
    logic [2:0]  tx_burst;    // derived
    logic [2:0]  rx_burst;    // derived
    logic        rx_valid;    // rx report
    logic        rx_wdog;     // rx report
    logic        rx_err;      // rx report
    logic        rx_good;     // rx report
    logic        tx_valid;    // tx answer
    logic        tx_allow;    // tx answer
    logic [17:0] since_sample; // cycles since last sample
  } state_t;

  state_t cur;              // registered state
  state_t next_cur;         // value for next edge
  logic [15:0] ext_view;    // command register as read
  logic [7:0]  link_sample; // fresh media picture
  logic [19:0] tx_limit;    // byte limit for tx
  logic        refresh;     // sample pulse

  // read image of the command register, reserved bits zero
  always_comb begin
    ext_view = 16'h0000;
    ext_view[gige_cfg_pkg::EC_ENDIAN]     = cur.endian;
    ext_view[gige_cfg_pkg::EC_TAG_STRIP]  = cur.tag_strip;
    ext_view[gige_cfg_pkg::EC_CSUM]       = cur.csum;
    ext_view[gige_cfg_pkg::EC_DUAL_ADDR]  = cur.dual_addr;
    ext_view[gige_cfg_pkg::EC_MULTI_XFER] = cur.multi_xfer;
  end

  // media picture; speed bits only mean something per interface
  always_comb begin
    link_sample = 8'h00;
    link_sample[gige_cfg_pkg::LS_TX_PAUSE] = PHY_TX_PAUSE;
    link_sample[gige_cfg_pkg::LS_RX_PAUSE] = PHY_RX_PAUSE;
    link_sample[gige_cfg_pkg::LS_GIG_FULL] =
      (MEDIA_MODE == gige_cfg_pkg::MEDIA_GMII) &
      PHY_GIG & PHY_FULL;
    link_sample[gige_cfg_pkg::LS_SPEED_100] =
      (MEDIA_MODE != gige_cfg_pkg::MEDIA_TBI) & PHY_HUNDRED;
    link_sample[gige_cfg_pkg::LS_SPEED_10] =
      (MEDIA_MODE != gige_cfg_pkg::MEDIA_TBI) & PHY_TEN;
    link_sample[gige_cfg_pkg::LS_LINK_UP] = PHY_LINK;
    link_sample[gige_cfg_pkg::LS_DUPLEX]  = PHY_FULL;
  end

  // tx limit: unit count, clamped to the jumbo ceiling above 0x3B
  // below the threshold no cap applies; a slow bus may then underrun
  // on long frames, a risk the driver has to weigh
  always_comb begin
    tx_limit = 20'(cur.tx_max) * 20'(TX_UNIT_BYTES);
    if (cur.tx_max > gige_cfg_pkg::TX_JUMBO_THRESH &&
        tx_limit > gige_cfg_pkg::TX_JUMBO_LIMIT) begin
      tx_limit = gige_cfg_pkg::TX_JUMBO_LIMIT;
    end
  end

  assign refresh = (cur.refresh_cnt == 17'h00000);

  // next state of every register
  always_comb begin
    next_cur = cur;
    // periodic status refresh; the counter reloads on each sample
    // the age counter only feeds the refresh check below
    if (refresh) begin
      next_cur.link_status = link_sample;
      next_cur.refresh_cnt = 17'(REFRESH_CYCLES - 1);
      next_cur.since_sample = 18'h00000;
    end else begin
      next_cur.refresh_cnt = cur.refresh_cnt - 17'h00001;
      next_cur.since_sample = cur.since_sample + 18'h00001;
    end

    // host writes; link status has no write path at all
    if (WR) begin
      case (ADDR)
        gige_cfg_pkg::ADDR_RX_MAX_SIZE: begin
          // full 14-bit range accepted, up to 16383
          if (WSIZE != gige_cfg_pkg::SIZE_BYTE) begin
            next_cur.rx_max = WDATA[13:0];
          end else begin
            next_cur.rx_max[7:0] = WDATA[7:0];
          end
        end
        gige_cfg_pkg::ADDR_EXT_COMMAND: begin
          // byte writes dropped so half a command never lands
          if (WSIZE == gige_cfg_pkg::SIZE_WORD) begin
            next_cur.endian     = WDATA[gige_cfg_pkg::EC_ENDIAN];
            next_cur.tag_strip  = WDATA[gige_cfg_pkg::EC_TAG_STRIP];
            next_cur.csum       = WDATA[gige_cfg_pkg::EC_CSUM];
            next_cur.dual_addr  = WDATA[gige_cfg_pkg::EC_DUAL_ADDR];
            next_cur.multi_xfer = WDATA[gige_cfg_pkg::EC_MULTI_XFER];
          end
        end
        gige_cfg_pkg::ADDR_RX_RING_LO: begin
          // alignment bits are not stored and read back zero
          next_cur.ring_base[23:0] = WDATA[31:8];
        end
        gige_cfg_pkg::ADDR_RX_RING_HI: begin
          next_cur.ring_base[55:24] = WDATA;
        end
        gige_cfg_pkg::ADDR_TX_MAX_SIZE: begin
          next_cur.tx_max = WDATA[5:0];
        end
        default: begin
          // unmapped or read-only: nothing changes
          next_cur.rx_max = cur.rx_max;
        end
      endcase
    end

    // read answer, valid only in the cycle after the strobe
    // a zero default keeps stale data off the bus between reads
    next_cur.rdata = 32'h00000000;
    if (RD) begin
      case (ADDR)
        gige_cfg_pkg::ADDR_LINK_STATUS:
          next_cur.rdata = {24'h000000, cur.link_status};
        gige_cfg_pkg::ADDR_RX_MAX_SIZE:
          next_cur.rdata = {18'h00000, cur.rx_max};
        gige_cfg_pkg::ADDR_EXT_COMMAND:
          next_cur.rdata = {16'h0000, ext_view};
        gige_cfg_pkg::ADDR_RX_RING_LO:
          next_cur.rdata = {cur.ring_base[23:0], 8'h00};
        gige_cfg_pkg::ADDR_RX_RING_HI:
          next_cur.rdata = cur.ring_base[55:24];
        gige_cfg_pkg::ADDR_TX_MAX_SIZE:
          next_cur.rdata = {26'h0000000, cur.tx_max};
        default:
          next_cur.rdata = 32'h00000000;
      endcase
    end

    // derived controls, refreshed every cycle
    // they trail the registers by one cycle, too short for software
    next_cur.rx_enable = (cur.rx_max != 14'h0000);
    next_cur.dual_rx   = cur.dual_addr &
                         (cur.ring_base[55:24] != 32'h00000000);
    // multi transfer mode makes programmed burst sizes moot
    next_cur.tx_burst  = cur.multi_xfer ?
                         gige_cfg_pkg::BURST_UNLIMITED : TX_BURST_CFG;
    next_cur.rx_burst  = cur.multi_xfer ?
                         gige_cfg_pkg::BURST_UNLIMITED : RX_BURST_CFG;

    // receive status flags for the packet just finished
    next_cur.rx_valid = RX_DONE;
    next_cur.rx_wdog  = 1'b0;
    next_cur.rx_err   = 1'b0;
    next_cur.rx_good  = 1'b0;
    if (RX_DONE) begin
      if (cur.rx_max > gige_cfg_pkg::RX_LONG_LIMIT &&
          RX_LEN > gige_cfg_pkg::RX_LONG_LIMIT) begin
        next_cur.rx_wdog = 1'b1;
        next_cur.rx_err  = 1'b1;
      end
      if (RX_CRC_ERR) begin
        next_cur.rx_err = 1'b1;
      end
      // flags above do not spoil a long packet with good crc
      next_cur.rx_good = ~RX_CRC_ERR & (RX_LEN <= cur.rx_max) &
                         cur.rx_enable;
    end

    // transmit length answer; below 0x3B the unit limit stands
    next_cur.tx_valid = TX_REQ;
    next_cur.tx_allow = TX_REQ & (cur.tx_max != 6'h00) &
                        (20'(TX_LEN) <= tx_limit);
  end

  // state register
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      cur             <= '0;
      cur.link_status <= gige_cfg_pkg::RST_LINK_STATUS;
      cur.rx_max      <= gige_cfg_pkg::RST_RX_MAX_SIZE;
      cur.tx_max      <= gige_cfg_pkg::RST_TX_MAX_SIZE;
      cur.dual_addr   <= 1'b0;
    end else begin
      cur <= next_cur;
    end
  end

  // outputs straight from the state register
  assign RDATA         = cur.rdata;
  assign RX_ENABLE     = cur.rx_enable;
  assign TAG_STRIP_EN  = cur.tag_strip;
  assign CSUM_EN       = cur.csum;
  assign DUAL_ADDR_RX  = cur.dual_rx;
  assign BIG_ENDIAN    = cur.endian;
  assign TX_BURST      = cur.tx_burst;
  assign RX_BURST      = cur.rx_burst;
  assign RING_BASE     = {cur.ring_base, 8'h00};
  assign RX_STAT_VALID = cur.rx_valid;
  assign RX_WDOG_FLAG  = cur.rx_wdog;
  assign RX_ERR_FLAG   = cur.rx_err;
  assign RX_GOOD       = cur.rx_good;
  assign TX_ANS_VALID  = cur.tx_valid;
  assign TX_ALLOW      = cur.tx_allow;

  // checks share the one bus clock and stay quiet while reset is held
  // the sample age lives in the state so the refresh check can see it
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);

  a_status_refresh: assert property (
    cur.since_sample < 18'(REFRESH_CYCLES))
    else $error("link status not refreshed in time");

  a_pause_bits: assert property (
    refresh |=> cur.link_status[6:5] == $past({PHY_TX_PAUSE, PHY_RX_PAUSE}))
    else $error("pause bits do not follow media");

  a_gig_gmii_only: assert property (
    refresh && MEDIA_MODE != gige_cfg_pkg::MEDIA_GMII |=>
      !cur.link_status[4])
    else $error("gigabit bit set outside gmii");

  a_link_bits: assert property (
    refresh |=> cur.link_status[1:0] == $past({PHY_LINK, PHY_FULL}))
    else $error("link or duplex bit wrong");

  a_status_no_write: assert property (
    !refresh |=> $stable(cur.link_status))
    else $error("link status changed without a sample");

  a_cmd_byte_write: assert property (
    WR && ADDR == gige_cfg_pkg::ADDR_EXT_COMMAND &&
    WSIZE != gige_cfg_pkg::SIZE_WORD |=> $stable(ext_view))
    else $error("command register took a byte write");

  a_strip_follows: assert property (
    WR && ADDR == gige_cfg_pkg::ADDR_EXT_COMMAND &&
    WSIZE == gige_cfg_pkg::SIZE_WORD |=> TAG_STRIP_EN == $past(WDATA[6]))
    else $error("tag strip enable not written");

  a_long_rx_flags: assert property (
    RX_DONE && cur.rx_max > 14'h1FFF && RX_LEN > 14'h1FFF |=>
      RX_WDOG_FLAG && RX_ERR_FLAG)
    else $error("long packet flags missing");

  a_long_rx_good: assert property (
    RX_DONE && !RX_CRC_ERR && RX_LEN <= cur.rx_max && cur.rx_enable |=>
      RX_GOOD)
    else $error("good long packet rejected");

  a_tx_jumbo_cap: assert property (
    TX_REQ && cur.tx_max > 6'h3B && TX_LEN > 14'h1D10 |=> !TX_ALLOW)
    else $error("tx above jumbo ceiling allowed");

  a_dual_addr: assert property (
    ##1 DUAL_ADDR_RX |-> $past(cur.dual_addr) && $past(RING_BASE[63:32]) != 0)
    else $error("dual address used with zero high word");

  a_burst_override: assert property (
    cur.multi_xfer |=> TX_BURST == 3'h7 && RX_BURST == 3'h7)
    else $error("burst not overridden");

  a_ring_align: assert property (
    RING_BASE[7:0] == 8'h00)
    else $error("ring base not aligned");

  a_read_timing: assert property (
    RD && ADDR == gige_cfg_pkg::ADDR_RX_RING_HI |=>
      RDATA == $past(RING_BASE[63:32]))
    else $error("ring high word read wrong");

  a_speed_tbi_zero: assert property (
    refresh && MEDIA_MODE == gige_cfg_pkg::MEDIA_TBI |=>
      cur.link_status[3:2] == 2'h0)
    else $error("speed bits set in tbi mode");

  a_csum_follows: assert property (
    WR && ADDR == gige_cfg_pkg::ADDR_EXT_COMMAND &&
    WSIZE == gige_cfg_pkg::SIZE_WORD |=> CSUM_EN == $past(WDATA[5]))
    else $error("checksum offload enable not written");

  a_rx_size_word: assert property (
    WR && ADDR == gige_cfg_pkg::ADDR_RX_MAX_SIZE &&
    WSIZE != gige_cfg_pkg::SIZE_BYTE |=> cur.rx_max == $past(WDATA[13:0]))
    else $error("rx size limit not taken whole");

  a_ring_low_write: assert property (
    WR && ADDR == gige_cfg_pkg::ADDR_RX_RING_LO |=>
      RING_BASE[31:8] == $past(WDATA[31:8]))
    else $error("ring base low word not written");

endmodule : gige_mac_config_status_regs

// ---- dv/tb.sv ----
// Purpose: self-checking bench for the gigabit register bank
// Assumes: refresh period shortened to 16 cycles for the run
// Notes:   stimulus launched by non-blocking assignment on clk; phy and media 1 ns after an edge
`timescale 1ns/1ps

module tb;
  localparam int REFRESH = 16;  // short refresh keeps the run brief
  logic        clk;      // 250 MHz bus clock
  logic        sys_rst;  // sync reset, active high
  logic [7:0]  addr;     // register byte address
  logic [31:0] wdata;    // write data
  logic [1:0]  wsize;    // write width code
  logic        wr;       // write strobe
  logic        rd;       // read strobe
  logic [31:0] rdata;    // read data
  logic [1:0]  media;    // media interface kind
  logic [6:0]  phy;      // tx,rx pause, gig, 100, 10, link, full
  logic [2:0]  tx_cfg;   // programmed tx burst
  logic [2:0]  rx_cfg;   // programmed rx burst
  logic        rx_done;  // end of packet pulse
  logic [13:0] rx_len;   // packet length
  logic        rx_crc;   // crc error
  logic        tx_req;   // length query pulse
  logic [13:0] tx_len;   // queried length
  logic        rx_en, strip, csum, dual, big_end; // control outputs
  logic [2:0]  tx_burst, rx_burst; // effective bursts
  logic [63:0] ring;     // ring base
  logic        rx_valid, wdog, err, good, tx_valid, tx_allow; // answers
  logic [31:0] d;        // scratch read value
  int          fail_count; // mismatches
  int          checks;     // comparisons made

  gige_mac_config_status_regs #(
    .REFRESH_CYCLES(REFRESH),
    .TX_UNIT_BYTES (128)
  ) u_gige_mac_config_status_regs (
    .CLK(clk), .SYS_RST(sys_rst), .ADDR(addr), .WDATA(wdata),
    .WSIZE(wsize), .WR(wr), .RD(rd), .RDATA(rdata),
    .MEDIA_MODE(media), .PHY_LINK(phy[1]), .PHY_FULL(phy[0]),
    .PHY_GIG(phy[4]), .PHY_HUNDRED(phy[3]), .PHY_TEN(phy[2]),
    .PHY_TX_PAUSE(phy[6]), .PHY_RX_PAUSE(phy[5]),
    .TX_BURST_CFG(tx_cfg), .RX_BURST_CFG(rx_cfg),
    .RX_DONE(rx_done), .RX_LEN(rx_len), .RX_CRC_ERR(rx_crc),
    .TX_REQ(tx_req), .TX_LEN(tx_len), .RX_ENABLE(rx_en),
    .TAG_STRIP_EN(strip), .CSUM_EN(csum), .DUAL_ADDR_RX(dual),
    .BIG_ENDIAN(big_end), .TX_BURST(tx_burst), .RX_BURST(rx_burst),
    .RING_BASE(ring), .RX_STAT_VALID(rx_valid), .RX_WDOG_FLAG(wdog),
    .RX_ERR_FLAG(err), .RX_GOOD(good), .TX_ANS_VALID(tx_valid),
    .TX_ALLOW(tx_allow)
  );

  // free-running clock, 4 ns period
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // one comparison, four-state exact
  task automatic chk(input string name, input logic [63:0] exp,
                     input logic [63:0] got);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %s expected %0h seen %0h", name, exp, got);
    end
  endtask : chk

  // single-cycle write; strobe dropped at the next edge
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] v,
                        input logic [1:0] s);
    @(posedge clk);
    wr <= 1'b1; addr <= a; wdata <= v; wsize <= s;
    @(posedge clk);
    wr <= 1'b0;
  endtask : reg_wr

  // single-cycle read; data stand only in the following cycle
  task automatic reg_rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    rd <= 1'b1; addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask : reg_rd

  // let registered outputs settle
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : wait_cyc

  // one received packet report and its flags
  task automatic rx_pkt(input logic [13:0] l, input logic c,
                        input logic [2:0] exp);
    @(posedge clk);
    rx_done <= 1'b1; rx_len <= l; rx_crc <= c;
    @(posedge clk);
    rx_done <= 1'b0;
    #1 chk("rx flags", {1'b1, exp}, {rx_valid, wdog, err, good});
  endtask : rx_pkt

  // one transmit length query
  task automatic tx_pkt(input logic [13:0] l, input logic exp);
    @(posedge clk);
    tx_req <= 1'b1; tx_len <= l;
    @(posedge clk);
    tx_req <= 1'b0;
    #1 chk("tx allow", {1'b1, exp}, {tx_valid, tx_allow});
  endtask : tx_pkt

  // reset values and the unmapped hole
  task automatic t_reset;
    logic [7:0] regs[6];
    regs = '{8'h6C, 8'hDA, 8'hE0, 8'hE4, 8'hE8, 8'hEC};
    foreach (regs[i]) begin
      reg_rd(regs[i], d);
      chk("reset read", 64'h0, d);
    end
    reg_rd(8'h10, d);
    chk("unmapped read", 64'h0, d);
    chk("reset outs", 64'h0, {rx_en, strip, csum, dual, big_end});
    chk("reset ring", 64'h0, ring);
    chk("burst pass", {tx_cfg, rx_cfg}, {tx_burst, rx_burst});
    $display("test reset done");
  endtask : t_reset

  // status tracks live media state per interface kind
  task automatic t_link;
    logic [6:0] vec[3];
    logic [7:0] e;
    vec = '{7'h7F, 7'h2A, 7'h11};
    foreach (vec[v]) for (int m = 0; m < 3; m++) begin
      phy <= vec[v];
      media <= m[1:0];
      wait_cyc(REFRESH + 2);
      reg_wr(8'h6C, 32'h0000_00FF, gige_cfg_pkg::SIZE_BYTE);
      e = {1'b0, vec[v][6:5],
           vec[v][4] & vec[v][0] & (m[1:0] == gige_cfg_pkg::MEDIA_GMII),
           vec[v][3:2] & {2{m[1:0] != gige_cfg_pkg::MEDIA_TBI}},
           vec[v][1:0]};
      reg_rd(8'h6C, d);
      chk("link status", e, d);
    end
    $display("test link done");
  endtask : t_link

  // command register: word only, control bits
  task automatic t_cmd;
    reg_wr(8'hE0, 32'h0000_0278, gige_cfg_pkg::SIZE_BYTE);
    reg_rd(8'hE0, d);
    chk("cmd byte ignored", 64'h0, d);
    reg_wr(8'hE0, 32'h0000_0278, gige_cfg_pkg::SIZE_WORD);
    wait_cyc(2);
    chk("cmd outs", 64'hE, {strip, csum, big_end, dual});
    chk("burst override", 64'h3F, {tx_burst, rx_burst});
    reg_wr(8'hE0, 32'h0, gige_cfg_pkg::SIZE_DWORD);
    reg_wr(8'hE0, 32'h0, gige_cfg_pkg::SIZE_BYTE);
    reg_rd(8'hE0, d);
    chk("cmd kept", 64'h278, d);
    wait_cyc(1);
    chk("rdata one cycle", 64'h0, rdata);
    reg_wr(8'hE0, 32'h0000_0010, gige_cfg_pkg::SIZE_WORD);
    wait_cyc(2);
    chk("cmd cleared", 64'h0, {strip, csum, big_end});
    chk("burst back", {tx_cfg, rx_cfg}, {tx_burst, rx_burst});
    $display("test command done");
  endtask : t_cmd

  // ring base halves, alignment and dual address gating
  task automatic t_ring;
    reg_wr(8'hE4, 32'h1234_56FF, gige_cfg_pkg::SIZE_DWORD);
    reg_wr(8'hE8, 32'h0, gige_cfg_pkg::SIZE_DWORD);
    reg_rd(8'hE4, d);
    chk("ring low", 64'h1234_5600, d);
    chk("ring out", 64'h1234_5600, ring);
    chk("dual high zero", 64'h0, dual);
    reg_wr(8'hE8, 32'h0000_00AB, gige_cfg_pkg::SIZE_DWORD);
    reg_rd(8'hE8, d);
    chk("ring high", 64'hAB, d);
    chk("ring out hi", 64'hAB_1234_5600, ring);
    chk("dual high set", 64'h1, dual);
    reg_wr(8'hE0, 32'h0, gige_cfg_pkg::SIZE_WORD);
    wait_cyc(2);
    chk("dual off", 64'h0, dual);
    $display("test ring done");
  endtask : t_ring

  // receive size limit and long-packet flags
  task automatic t_rx;
    reg_wr(8'hDA, 32'h0000_3FFF, gige_cfg_pkg::SIZE_WORD);
    reg_rd(8'hDA, d);
    chk("rx size max", 64'h3FFF, d);
    chk("rx enable", 64'h1, rx_en);
    rx_pkt(14'd9000, 1'b0, 3'b111);
    rx_pkt(14'd9000, 1'b1, 3'b110);
    rx_pkt(14'd8191, 1'b0, 3'b001);
    reg_wr(8'hDA, 32'h0000_1FFF, gige_cfg_pkg::SIZE_WORD);
    rx_pkt(14'd8191, 1'b0, 3'b001);
    rx_pkt(14'd8192, 1'b0, 3'b000);
    reg_wr(8'hDA, 32'h0000_0005, gige_cfg_pkg::SIZE_BYTE);
    reg_rd(8'hDA, d);
    chk("rx size byte", 64'h1F05, d);
    reg_wr(8'hDA, 32'h0, gige_cfg_pkg::SIZE_WORD);
    wait_cyc(2);
    chk("rx disabled", 64'h0, rx_en);
    rx_pkt(14'd64, 1'b0, 3'b000);
    $display("test rx done");
  endtask : t_rx

  // transmit size units and the jumbo cap
  task automatic t_tx;
    reg_wr(8'hEC, 32'h0000_000C, gige_cfg_pkg::SIZE_BYTE);
    reg_rd(8'hEC, d);
    chk("tx size", 64'h0C, d);
    tx_pkt(14'd1522, 1'b1);
    tx_pkt(14'd1536, 1'b1);
    tx_pkt(14'd1537, 1'b0);
    reg_wr(8'hEC, 32'h0000_003F, gige_cfg_pkg::SIZE_BYTE);
    tx_pkt(14'd7440, 1'b1);
    tx_pkt(14'd7441, 1'b0);
    reg_wr(8'hEC, 32'h0000_003B, gige_cfg_pkg::SIZE_BYTE);
    tx_pkt(14'd7552, 1'b1);
    reg_wr(8'hEC, 32'h0000_003A, gige_cfg_pkg::SIZE_BYTE);
    tx_pkt(14'd7424, 1'b1);
    tx_pkt(14'd7425, 1'b0);
    reg_wr(8'hEC, 32'h0, gige_cfg_pkg::SIZE_BYTE);
    tx_pkt(14'd1, 1'b0);
    $display("test tx done");
  endtask : t_tx

  // verdict and end of run
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : report_and_stop

  // hang guard: a run past this bound counts as a mismatch
  initial begin
    repeat (100000) @(posedge clk);
    fail_count++;
    report_and_stop();
  end

  // main sequence
  initial begin
    fail_count = 0; checks = 0;
    sys_rst = 1'b1; addr = 8'h0; wdata = 32'h0; wsize = 2'h0;
    wr = 1'b0; rd = 1'b0; media = 2'h0; phy = 7'h0;
    tx_cfg = 3'h2; rx_cfg = 3'h5; rx_done = 1'b0; rx_len = 14'h0;
    rx_crc = 1'b0; tx_req = 1'b0; tx_len = 14'h0;
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    wait_cyc(3);
    t_reset();
    t_cmd();
    t_link();
    t_ring();
    t_rx();
    t_tx();
    report_and_stop();
  end
endmodule : tb
